// File: common/spicfg_pkg.sv
// shared constants and types for the spi clock and frame configuration block
package spicfg_pkg;
  // register map (word index over the plain register port)
  localparam logic [3:0] ADDR_CON1 = 4'h0;
  localparam logic [3:0] ADDR_CON2 = 4'h1;
  localparam logic [3:0] ADDR_STAT = 4'h2;
  localparam logic [3:0] ADDR_DATA = 4'h3;
  // control register 1 fields (own layout)
  localparam int CON1_PRI_LSB = 0;
  localparam int CON1_SEC_LSB = 2;
  localparam int CON1_MASTER = 5;
  localparam int CON1_ENABLE = 6;
  localparam int CON1_SCK_DIS = 7;
  localparam int CON1_SDO_DIS = 8;
  localparam int CON1_SS_EN = 9;
  localparam int CON1_CKE = 10;
  localparam logic [15:0] CON1_MASK = 16'h07FF;
  // frame and buffer control fields
  localparam int CON2_FRAMED_MODE_ENABLE = 15;
  localparam int CON2_FSD = 14;
  localparam int CON2_FPOL = 13;
  localparam int CON2_FE = 1;
  localparam int CON2_BEN = 0;
  localparam logic [15:0] CON2_MASK = 16'hE003;
  localparam logic [15:0] REG_RESET = 16'h0000;
  // status fields
  localparam int STAT_BUSY = 0;
  localparam int STAT_TXFULL = 1;
  localparam int STAT_RXVALID = 2;
  localparam int FIFO_DEPTH = 4;
  localparam int DATA_W = 8;
  localparam logic [2:0] BITS_LAST = 3'h7;
  localparam logic [2:0] SEC_ONE = 3'h7;
  localparam logic [1:0] PRI_ONE = 2'h3;

  typedef struct packed {
    logic [1:0] primary_clock_divide;
    logic [2:0] secondary_clock_divide;
    logic master;
    logic enable;
    logic serial_clock_pin_disable;
    logic data_out_pin_disable;
    logic slave_select_enable;
    logic cke;
    logic framed_mode_enable;
    logic frame_sync_direction;
    logic frame_sync_polarity;
    logic frame_sync_edge_select;
    logic enhanced_buffer_enable;
  } spicfg_cfg_s;
endpackage : spicfg_pkg

// File: hdl/spicfg_clkdiv.sv
// master bit clock divider from primary and secondary prescale codes
`timescale 1ns/1ps
`default_nettype none
module spicfg_clkdiv (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // control
  input wire logic run,
  input wire logic [1:0] primary_clock_divide,
  input wire logic [2:0] secondary_clock_divide,
  // one-cycle pulse at each half bit period
  output logic half_tick
);
  logic [8:0] cnt, next_cnt;
  logic [8:0] limit;

  // primary 1,4,16,64 times secondary 1..8
  function automatic logic [8:0] div_of(input logic [1:0] p, input logic [2:0] s);
    logic [8:0] pr;
    logic [8:0] se;
    pr = 9'h001 << (9'(spicfg_pkg::PRI_ONE - p) * 2);     // R2
    se = 9'(spicfg_pkg::SEC_ONE - s) + 9'h001;           // R1
    return 9'(pr * se);
  endfunction : div_of

  assign limit = div_of(primary_clock_divide, secondary_clock_divide) - 9'h001;
  assign half_tick = run && (cnt == limit);

  always_comb begin
    next_cnt = (!run || half_tick) ? 9'h000 : cnt + 9'h001;
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      cnt <= 9'h000;
    end else begin
      cnt <= next_cnt;
    end
  end

  property p_div_period;
    @(posedge clk) disable iff (!rstn)
    (run && primary_clock_divide == 2'h3 && secondary_clock_divide == 3'h6 && half_tick
      && $stable(primary_clock_divide) && $stable(secondary_clock_divide))
    |=> !half_tick ##1 (half_tick || !run || $changed(secondary_clock_divide));
  endproperty
  a_div_period: assert property (p_div_period) else $error("2:1 divide wrong"); // R1
  property p_pri_div;
    @(posedge clk) disable iff (!rstn)
    (primary_clock_divide == 2'h2 && secondary_clock_divide == 3'h7) |-> limit == 9'h003;
  endproperty
  a_pri_div: assert property (p_pri_div) else $error("4:1 primary divide wrong"); // R2
  property p_sec_div;
    @(posedge clk) disable iff (!rstn)
    (primary_clock_divide == 2'h3 && secondary_clock_divide == 3'h0) |-> limit == 9'h007;
  endproperty
  a_sec_div: assert property (p_sec_div) else $error("8:1 secondary divide wrong"); // R1
  // a stopped divider restarts from zero, so the first half bit is whole
  property p_div_stop;
    @(posedge clk) disable iff (!rstn)
    !run |=> cnt == 9'h000;
  endproperty
  a_div_stop: assert property (p_div_stop) else $error("divider not cleared when stopped"); // R3
endmodule : spicfg_clkdiv
`default_nettype wire

// File: hdl/spicfg_fifo.sv
// small synchronous fifo with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module spicfg_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wp, rp, next_wp, next_rp;
  logic [AW:0] cnt, next_cnt;
  logic push, pop;

  assign in_ready = (cnt != (AW+1)'(DEPTH));
  assign out_valid = (cnt != '0);
  assign out_data = mem[rp];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    next_wp = push ? wp + 1'b1 : wp;
    next_rp = pop ? rp + 1'b1 : rp;
    next_cnt = cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      wp <= '0;
      rp <= '0;
      cnt <= '0;
    end else begin
      wp <= next_wp;
      rp <= next_rp;
      cnt <= next_cnt;
    end
    if (push) begin
      mem[wp] <= in_data;
    end
  end

  property p_fifo_bound;
    @(posedge clk) disable iff (!rstn)
    cnt <= (AW+1)'(DEPTH);
  endproperty
  a_fifo_bound: assert property (p_fifo_bound) else $error("fifo count beyond depth"); // R10
  property p_fifo_push;
    @(posedge clk) disable iff (!rstn)
    push && !pop |=> cnt == $past(cnt) + 1'b1;
  endproperty
  a_fifo_push: assert property (p_fifo_push) else $error("fifo push not counted"); // R10
  property p_fifo_pop;
    @(posedge clk) disable iff (!rstn)
    pop && !push |=> cnt == $past(cnt) - 1'b1;
  endproperty
  a_fifo_pop: assert property (p_fifo_pop) else $error("fifo pop not counted"); // R10
endmodule : spicfg_fifo
`default_nettype wire

// File: hdl/spicfg_top.sv
// spi unit: clock prescalers, framed sync pulse, enhanced buffer and register port
// How it works
// (R1) master bit clock divided by secondary code: 111 is 1:1 down to 000 as 8:1.
// (R2) primary code picks 1:1, 4:1, 16:1 or 64:1 in master operation.
// (R3) prescalers only matter as master; slave takes clock from far end.
// (R4) clock edge bit ignored in framed mode; software should write it zero.
// (R5) edge select 1: sync with first bit clock; 0: one bit clock before.
// (R6) with clock pin enabled software maps serial clock onto a remappable pin.
// (R7) with data-out enabled software maps serial data output onto a remappable pin.
// (R8) with slave select enabled software maps slave select onto a remappable pin.
// (R9) framed enable, sync direction (1 input) and polarity (1 active high) bits.
// (R10) buffer enable picks fifo or single buffer (legacy mode here keeps the four-word fifo, flagging full at one word); unimplemented bits read zero.
//
// The implementer's own choices: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module spicfg_top (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  // serial clock pin
  input wire logic serial_clock_in,
  output logic serial_clock_out,
  output logic serial_clock_oe,
  // data pins
  input wire logic serial_data_in,
  output logic serial_data_output,
  output logic serial_data_oe,
  // slave select and frame sync pin
  input wire logic slave_select_in,
  output logic slave_select_out,
  output logic slave_select_oe
);
  typedef enum {ST_IDLE, ST_SYNC, ST_SHIFT} spicfg_state_e;

  logic [15:0] con1, next_con1, con2, next_con2;
  logic [15:0] next_rdata;
  spicfg_pkg::spicfg_cfg_s cfg;
  spicfg_state_e state, next_state;
  logic [7:0] sh, next_sh, rx, next_rx;
  logic [2:0] bitn, next_bitn;
  logic sck, next_sck, rxv, next_rxv, fs, next_fs;
  logic sck_in_q, next_sck_in_q, ss_in_q, next_ss_in_q;
  logic half_tick, is_master, fifo_out_valid, fifo_pop, fifo_in_ready, tx_write;
  logic [7:0] fifo_out_data;
  logic lead_edge, trail_edge, frame_start, busy;

  always_comb begin
    cfg.primary_clock_divide = con1[spicfg_pkg::CON1_PRI_LSB +: 2];
    cfg.secondary_clock_divide = con1[spicfg_pkg::CON1_SEC_LSB +: 3];
    cfg.master = con1[spicfg_pkg::CON1_MASTER];
    cfg.enable = con1[spicfg_pkg::CON1_ENABLE];
    cfg.serial_clock_pin_disable = con1[spicfg_pkg::CON1_SCK_DIS];
    cfg.data_out_pin_disable = con1[spicfg_pkg::CON1_SDO_DIS];
    cfg.slave_select_enable = con1[spicfg_pkg::CON1_SS_EN];
    cfg.cke = con1[spicfg_pkg::CON1_CKE];
    cfg.framed_mode_enable = con2[spicfg_pkg::CON2_FRAMED_MODE_ENABLE]; // R9
    cfg.frame_sync_direction = con2[spicfg_pkg::CON2_FSD]; // R9
    cfg.frame_sync_polarity = con2[spicfg_pkg::CON2_FPOL]; // R9
    cfg.frame_sync_edge_select = con2[spicfg_pkg::CON2_FE];
    cfg.enhanced_buffer_enable = con2[spicfg_pkg::CON2_BEN];
  end

  assign is_master = cfg.enable && cfg.master;
  assign tx_write = reg_wr && (reg_addr == spicfg_pkg::ADDR_DATA);

  // prescalers are clocked only while this end drives the clock
  spicfg_clkdiv u_div (
    .clk(clk),
    .rstn(rstn),
    .run(is_master && state != ST_IDLE), // R3
    .primary_clock_divide(cfg.primary_clock_divide),
    .secondary_clock_divide(cfg.secondary_clock_divide),
    .half_tick(half_tick)
  );

  // legacy mode still uses the fifo at its full four-word depth; only the full flag stops at one word
  spicfg_fifo #(.WIDTH(spicfg_pkg::DATA_W), .DEPTH(spicfg_pkg::FIFO_DEPTH)) u_fifo (
    .clk(clk),
    .rstn(rstn),
    .in_valid(tx_write),
    .in_ready(fifo_in_ready),
    .in_data(reg_wdata[7:0]),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_out_data)
  );

  // register writes and reads; reserved bits masked to zero
  always_comb begin
    next_con1 = con1;
    next_con2 = con2;
    next_rdata = 16'h0000;
    if (reg_wr && reg_addr == spicfg_pkg::ADDR_CON1) begin
      next_con1 = reg_wdata & spicfg_pkg::CON1_MASK;
    end
    if (reg_wr && reg_addr == spicfg_pkg::ADDR_CON2) begin
      next_con2 = reg_wdata & spicfg_pkg::CON2_MASK; // R10
    end
    if (reg_rd) begin
      case (reg_addr)
        spicfg_pkg::ADDR_CON1: next_rdata = con1;
        spicfg_pkg::ADDR_CON2: next_rdata = con2; // R10
        spicfg_pkg::ADDR_STAT: begin
          next_rdata[spicfg_pkg::STAT_BUSY] = busy;
          next_rdata[spicfg_pkg::STAT_TXFULL] = !tx_space();
          next_rdata[spicfg_pkg::STAT_RXVALID] = rxv;
        end
        spicfg_pkg::ADDR_DATA: next_rdata = {8'h00, rx};
        default: next_rdata = 16'h0000;
      endcase
    end
  end

  // single-buffer mode reports full once one word waits
  function automatic logic tx_space();
    return cfg.enhanced_buffer_enable ? fifo_in_ready : !fifo_out_valid; // R10
  endfunction : tx_space

  always_ff @(posedge clk) begin
    if (!rstn) begin
      con1 <= spicfg_pkg::REG_RESET;
      con2 <= spicfg_pkg::REG_RESET;
      reg_rdata <= 16'h0000;
    end else begin
      con1 <= next_con1;
      con2 <= next_con2;
      reg_rdata <= next_rdata;
    end
  end

  // bit edges: own divider as master, sampled pin as slave
  assign lead_edge = is_master ? (half_tick && !sck) : (serial_clock_in && !sck_in_q); // R3
  assign trail_edge = is_master ? (half_tick && sck) : (!serial_clock_in && sck_in_q);
  // framed slave-sync: start on incoming sync pulse, else on queued data
  assign frame_start = (cfg.framed_mode_enable && cfg.frame_sync_direction)
    ? (ss_in_q != cfg.frame_sync_polarity && slave_select_in == cfg.frame_sync_polarity) // R9
    : fifo_out_valid;
  assign busy = (state != ST_IDLE);
  assign fifo_pop = (state == ST_IDLE) && cfg.enable && fifo_out_valid && frame_start;

  // clock edge bit ignored when framed: sampling fixed at leading edge
  always_comb begin
    next_state = state;
    next_sh = sh;
    next_rx = rx;
    next_bitn = bitn;
    // no bit clock while the sync pulse runs alone
    next_sck = (state != ST_SHIFT || !is_master) ? 1'b0 : (half_tick ? !sck : sck);
    next_rxv = rxv;
    next_fs = 1'b0;
    next_sck_in_q = serial_clock_in;
    next_ss_in_q = slave_select_in;
    if (reg_rd && reg_addr == spicfg_pkg::ADDR_DATA) begin
      next_rxv = 1'b0;
    end
    case (state)
      ST_IDLE: begin
        if (fifo_pop) begin
          next_sh = fifo_out_data;
          next_bitn = 3'h0;
          // edge select 0 spends one bit clock on sync alone
          next_state = (cfg.framed_mode_enable && !cfg.frame_sync_edge_select) ? ST_SYNC : ST_SHIFT; // R5
          next_fs = cfg.framed_mode_enable && !cfg.frame_sync_direction;
        end
      end
      ST_SYNC: begin
        next_fs = !cfg.frame_sync_direction; // R5
        // master counts two half ticks with the clock held low
        if (is_master ? half_tick : trail_edge) begin
          next_bitn = bitn + 3'h1;
          if (bitn != 3'h0 || !is_master) begin
            next_state = ST_SHIFT;
            next_bitn = 3'h0;
            next_fs = 1'b0;
          end
        end
      end
      ST_SHIFT: begin
        next_fs = fs && cfg.frame_sync_edge_select && (bitn == 3'h0) && !trail_edge; // R5
        if (lead_edge) begin
          next_rx = {rx[6:0], serial_data_in};
        end
        if (trail_edge) begin
          next_sh = {sh[6:0], 1'b0};
          next_bitn = bitn + 3'h1;
          if (bitn == spicfg_pkg::BITS_LAST) begin
            next_state = ST_IDLE;
            next_rxv = 1'b1; // set wins over read clear
          end
        end
      end
      default: next_state = ST_IDLE;
    endcase
    if (!cfg.enable) begin
      next_state = ST_IDLE;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      state <= ST_IDLE;
      sh <= 8'h00;
      rx <= 8'h00;
      bitn <= 3'h0;
      sck <= 1'b0;
      rxv <= 1'b0;
      fs <= 1'b0;
      sck_in_q <= 1'b0;
      ss_in_q <= 1'b0;
    end else begin
      state <= next_state;
      sh <= next_sh;
      rx <= next_rx;
      bitn <= next_bitn;
      sck <= next_sck;
      rxv <= next_rxv;
      fs <= next_fs;
      sck_in_q <= next_sck_in_q;
      ss_in_q <= next_ss_in_q;
    end
  end

  // pins; remap into the pin matrix is software's job
  assign serial_clock_out = sck;
  assign serial_clock_oe = is_master && !cfg.serial_clock_pin_disable; // R6
  assign serial_data_output = sh[7];
  assign serial_data_oe = cfg.enable && !cfg.data_out_pin_disable; // R7
  assign slave_select_out = fs ? cfg.frame_sync_polarity : !cfg.frame_sync_polarity; // R9
  assign slave_select_oe = cfg.enable && cfg.slave_select_enable // R8
    && cfg.framed_mode_enable && !cfg.frame_sync_direction; // R9

  property p_slave_no_tick;
    @(posedge clk) disable iff (!rstn)
    !is_master |-> !half_tick;
  endproperty
  a_slave_no_tick: assert property (p_slave_no_tick) else $error("divider ran in slave mode"); // R3
  property p_slave_sck_oe;
    @(posedge clk) disable iff (!rstn)
    !is_master |-> !serial_clock_oe;
  endproperty
  a_slave_sck_oe: assert property (p_slave_sck_oe) else $error("clock pin driven in slave mode"); // R3
  property p_slave_sck_idle;
    @(posedge clk) disable iff (!rstn)
    !is_master |=> !sck;
  endproperty
  a_slave_sck_idle: assert property (p_slave_sck_idle) else $error("own clock ran in slave mode"); // R3
  property p_reserved_zero;
    @(posedge clk) disable iff (!rstn)
    $past(reg_rd) && $past(reg_addr) == spicfg_pkg::ADDR_CON2 |-> (reg_rdata & ~spicfg_pkg::CON2_MASK) == 16'h0000;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits not zero"); // R10
  property p_unmapped_zero;
    @(posedge clk) disable iff (!rstn)
    $past(reg_rd) && $past(reg_addr) > spicfg_pkg::ADDR_DATA |-> reg_rdata == 16'h0000;
  endproperty
  a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped read not zero"); // R10
  property p_sync_before;
    @(posedge clk) disable iff (!rstn)
    (state == ST_IDLE && fifo_pop && cfg.framed_mode_enable && !cfg.frame_sync_edge_select)
    |=> state == ST_SYNC && fs;
  endproperty
  a_sync_before: assert property (p_sync_before) else $error("sync pulse not ahead of first bit"); // R5
  property p_sync_no_clock;
    @(posedge clk) disable iff (!rstn)
    state == ST_SYNC |=> !sck;
  endproperty
  a_sync_no_clock: assert property (p_sync_no_clock) else $error("bit clock during lone sync"); // R5
  property p_sync_with;
    @(posedge clk) disable iff (!rstn)
    (state == ST_IDLE && fifo_pop && cfg.framed_mode_enable && cfg.frame_sync_edge_select && !cfg.frame_sync_direction)
    |=> state == ST_SHIFT && fs;
  endproperty
  a_sync_with: assert property (p_sync_with) else $error("sync pulse not with first bit"); // R5
  property p_fs_pol;
    @(posedge clk) disable iff (!rstn)
    fs |-> slave_select_out == cfg.frame_sync_polarity;
  endproperty
  a_fs_pol: assert property (p_fs_pol) else $error("sync polarity wrong"); // R9
  property p_fs_dir;
    @(posedge clk) disable iff (!rstn)
    cfg.frame_sync_direction |-> !slave_select_oe;
  endproperty
  a_fs_dir: assert property (p_fs_dir) else $error("sync pin driven as input"); // R9
  property p_fs_off;
    @(posedge clk) disable iff (!rstn)
    (state == ST_IDLE && !cfg.framed_mode_enable) |=> !fs;
  endproperty
  a_fs_off: assert property (p_fs_off) else $error("sync pulse outside framed mode"); // R9
  property p_single_buf;
    @(posedge clk) disable iff (!rstn)
    (!cfg.enhanced_buffer_enable && fifo_out_valid) |-> !tx_space();
  endproperty
  a_single_buf: assert property (p_single_buf) else $error("legacy mode accepts second word"); // R10
  property p_master_pri;
    @(posedge clk) disable iff (!rstn)
    (is_master && cfg.primary_clock_divide == 2'h0 && cfg.secondary_clock_divide == 3'h7 && half_tick
      && $stable(con1)) |=> !half_tick [*8];
  endproperty
  a_master_pri: assert property (p_master_pri) else $error("64:1 divide too fast"); // R2
endmodule : spicfg_top
`default_nettype wire

// File: test/spicfg_slave_model.sv
// far-side serial slave that returns a reply byte msb first
`timescale 1ns/1ps
`default_nettype none
module spicfg_slave_model (
  // serial side
  input wire logic sclk,
  input wire logic mosi,
  output logic miso,
  // bench side
  input wire logic [7:0] reply,
  output logic [7:0] got
);
  logic [2:0] idx = 3'h0;
  // no select line in use, so the first bit must stand before the first rising edge
  assign miso = reply[3'h7 - idx];
  always @(posedge sclk) got <= {got[6:0], mosi};
  // next bit on falling edge, wraps after a whole byte
  always @(negedge sclk) idx <= idx + 3'h1;
endmodule : spicfg_slave_model
`default_nettype wire

// File: test/spicfg_top_test.sv
// self-checking bench for the spi configuration block
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) begin checks_done++; if ((a) !== (e)) begin failures++; $display("MISMATCH %s exp %h seen %h", n, e, a); end end
module spicfg_top_test;
  logic clk, rstn, reg_wr, reg_rd, sdi, sck, sdo, sck_oe, sdo_oe, ss_out, ss_oe;
  logic [3:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, v, rv, ev;
  logic [7:0] reply, got;
  logic [1:0] p;
  logic [2:0] s;
  logic fr_act, rdt, prv, fpol, ck;
  int failures, checks_done, cyc, age, fr_age, i, j, half;
  logic [15:0] exp_q[$];
  logic chk_q[$];
  int rise_q[$];
  spicfg_top i_dut (.clk(clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .serial_clock_in(1'b0), .serial_clock_out(sck),
    .serial_clock_oe(sck_oe), .serial_data_in(sdi), .serial_data_output(sdo), .serial_data_oe(sdo_oe),
    .slave_select_in(1'b0), .slave_select_out(ss_out), .slave_select_oe(ss_oe));
  spicfg_slave_model i_far (.sclk(sck), .mosi(sdo), .miso(sdi), .reply(reply), .got(got));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) rdt <= reg_rd;
  // outputs sampled on the falling edge, well away from the launching edge
  always @(negedge clk) begin
    cyc++;
    if (cyc > 30000) begin
      failures++;
      summarize();
    end
    if (rdt) begin
      ck = chk_q.pop_front();
      ev = exp_q.pop_front();
      if (ck) `CHK("rdata", ev, reg_rdata)
    end
    if (ss_out === fpol) age = 0;
    else age++;
    if (!prv && sck === 1'b1) begin
      if (rise_q.size() == 0) begin
        fr_act = (ss_out === fpol);
        fr_age = age;
      end
      rise_q.push_back(cyc);
    end
    prv = sck;
  end
  function automatic logic [15:0] con1(input logic [1:0] pp, input logic [2:0] ss, input logic [4:0] f);
    return {6'h00, f, ss, pp};
  endfunction : con1
  // write strobe left high so writes may follow with no gap
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    reg_rd <= 1'b0;
    @(posedge clk);
  endtask : wr
  task automatic idle();
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask : idle
  task automatic rd(input logic [3:0] a, input logic [15:0] e, input logic c);
    exp_q.push_back(e);
    chk_q.push_back(c);
    reg_addr <= a;
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    v = reg_rdata;
    @(posedge clk);
  endtask : rd
  // two quiet reads in a row: a queued word restarts one cycle after a frame
  task automatic wait_idle();
    int quiet;
    quiet = 0;
    for (int n = 0; n < 2000 && quiet < 2; n++) begin
      rd(spicfg_pkg::ADDR_STAT, 16'h0000, 1'b0);
      quiet = (v[spicfg_pkg::STAT_BUSY] === 1'b0) ? quiet + 1 : 0;
    end
  endtask : wait_idle
  task automatic xfer(input logic [15:0] c1);
    logic [7:0] d;
    d = 8'($urandom);
    reply <= 8'($urandom);
    wr(spicfg_pkg::ADDR_CON1, c1);
    rise_q.delete();
    wr(spicfg_pkg::ADDR_DATA, {8'h00, d});
    idle();
    idle();
    wait_idle();
    `CHK("tx_byte", d, got)
    `CHK("bit_count", 8, rise_q.size())
    rd(spicfg_pkg::ADDR_DATA, {8'h00, reply}, 1'b1);
  endtask : xfer
  task automatic summarize();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : summarize
  initial begin
    rstn = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reply = 8'h00;
    fpol = 1'b1;
    prv = 1'b0;
    failures = 0;
    checks_done = 0;
    cyc = 0;
    age = 0;
    void'($urandom(32'h141e892b));
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    for (i = 0; i < 16; i++) rd(i[3:0], spicfg_pkg::REG_RESET, 1'b1);
    // unmapped writes must leave no trace; cke kept zero for framed use
    for (i = 4; i < 16; i++) wr(i[3:0], 16'hFFFF);
    wr(spicfg_pkg::ADDR_CON1, 16'hFBFF);
    wr(spicfg_pkg::ADDR_CON2, 16'hFFFF);
    rd(spicfg_pkg::ADDR_CON1, 16'h03FF, 1'b1);
    rd(spicfg_pkg::ADDR_CON2, spicfg_pkg::CON2_MASK, 1'b1);
    for (i = 4; i < 16; i++) rd(i[3:0], 16'h0000, 1'b1);
    for (j = 0; j < 8; j++) begin
      rv = 16'($urandom);
      wr(spicfg_pkg::ADDR_CON2, rv);
      rd(spicfg_pkg::ADDR_CON2, rv & spicfg_pkg::CON2_MASK, 1'b1);
    end
    wr(spicfg_pkg::ADDR_CON2, 16'h0000);
    for (i = 0; i < 16; i++) begin
      wr(spicfg_pkg::ADDR_CON1, con1(2'h3, 3'h7, {1'b0, i[3:0]}));
      idle();
      @(negedge clk);
      `CHK("sck_oe", i[0] & i[1] & !i[2], sck_oe)
      `CHK("sdo_oe", i[1] & !i[3], sdo_oe)
      @(posedge clk);
    end
    for (i = 0; i < 11; i++) begin
      p = (i < 8) ? 2'h3 : 2'(i - 8);
      s = (i < 8) ? 3'(i) : 3'h7;
      half = (1 << (2 * (3 - p))) * (8 - s);
      xfer(con1(p, s, 5'h03));
      `CHK("bit_period", 2 * half, rise_q[1] - rise_q[0])
    end
    // framed master: every polarity and sync placement
    for (i = 0; i < 4; i++) begin
      fpol = i[0];
      wr(spicfg_pkg::ADDR_CON2, {2'h2, i[0], 11'h000, i[1], 1'b0});
      wr(spicfg_pkg::ADDR_CON1, con1(2'h2, 3'h7, 5'h13));
      idle();
      @(negedge clk);
      `CHK("ss_oe", 1'b1, ss_oe)
      `CHK("ss_idle", ~i[0], ss_out)
      @(posedge clk);
      xfer(con1(2'h2, 3'h7, 5'h13));
      `CHK("sync_at_first", i[1], fr_act)
      if (!i[1]) `CHK("sync_before", 1'b1, fr_age <= 16)
    end
    wr(spicfg_pkg::ADDR_CON2, 16'hC000);
    idle();
    @(negedge clk);
    `CHK("ss_oe_in", 1'b0, ss_oe)
    @(posedge clk);
    // full flag: one word without enhanced buffer, four with it
    for (j = 0; j < 2; j++) begin
      wr(spicfg_pkg::ADDR_CON2, {15'h0000, j[0]});
      wr(spicfg_pkg::ADDR_CON1, con1(2'h1, 3'h7, 5'h03));
      rise_q.delete();
      wr(spicfg_pkg::ADDR_DATA, 16'h00A5);
      repeat (3) idle();
      for (i = 0; i < 1 + 2 * j; i++) wr(spicfg_pkg::ADDR_DATA, 16'(i));
      rd(spicfg_pkg::ADDR_STAT, 16'h0000, 1'b0);
      `CHK("tx_full", ~j[0], v[spicfg_pkg::STAT_TXFULL])
      if (j == 1) begin
        wr(spicfg_pkg::ADDR_DATA, 16'h005A);
        rd(spicfg_pkg::ADDR_STAT, 16'h0000, 1'b0);
        `CHK("tx_full4", 1'b1, v[spicfg_pkg::STAT_TXFULL])
      end
      wait_idle();
      `CHK("drained_bits", 16 + 24 * j, rise_q.size())
    end
    // slave operation: prescalers unused, no clock driven
    rise_q.delete();
    wr(spicfg_pkg::ADDR_CON1, con1(2'h3, 3'h7, 5'h02));
    wr(spicfg_pkg::ADDR_DATA, 16'h0033);
    repeat (40) idle();
    `CHK("slave_clocks", 0, rise_q.size())
    `CHK("slave_sck_oe", 1'b0, sck_oe)
    summarize();
  end
endmodule : spicfg_top_test
`default_nettype wire
